// File: rtl/dbgsc_addr_match.sv
`timescale 1ns/1ps
module dbgsc_addr_match
#(
  parameter int WIDTH = 16
)
(
  // Compare operands
  input wire logic enable_in,
  input wire logic [WIDTH-1:0] addr_in,
  input wire logic [WIDTH-1:0] match_in,
  // Result
  output logic hit_out
);

  always_comb
  begin
    hit_out = enable_in && (addr_in == match_in); // R2
  end

endmodule

// File: rtl/dbgsc_cmd_decode.sv
`timescale 1ns/1ps
module dbgsc_cmd_decode
(
  // Command strobe
  input wire logic cmd_valid_in,
  input wire logic [dbgsc_pkg::DBGSC_CODE_W-1:0] cmd_code_in,
  // Processor state
  input wire logic cpu_wait_stop_in,
  // Decoded operation
  output dbgsc_pkg::dbgsc_op_t op_out
);
  import dbgsc_pkg::*;

  // Only background and status read work in wait or stop
  always_comb
  begin
    op_out = DBGSC_OP_NONE;
    if (cmd_valid_in)
    begin
      case (cmd_code_in)
        DBGSC_CMD_BACKGROUND: op_out = DBGSC_OP_BGND;
        DBGSC_CMD_READ_STATUS: op_out = DBGSC_OP_STAT_RD;
        DBGSC_CMD_WRITE_CONTROL: op_out = cpu_wait_stop_in ? DBGSC_OP_NONE : DBGSC_OP_CTRL_WR; // R14
        DBGSC_CMD_BREAK_READ: op_out = cpu_wait_stop_in ? DBGSC_OP_NONE : DBGSC_OP_BRK_RD; // R14
        DBGSC_CMD_BREAK_WRITE: op_out = cpu_wait_stop_in ? DBGSC_OP_NONE : DBGSC_OP_BRK_WR; // R14
        default: op_out = DBGSC_OP_NONE;
      endcase
    end
  end

endmodule

// File: rtl/dbgsc_debug_regs.sv
// Contract
// R1: Eight-bit status and control register
// R2: Sixteen-bit breakpoint address compared against bus
// R3: Registers reached only by serial commands
// R4: Permit bit frozen while background mode active
// R5: Four status bits are read-only
// R6: Clock select writable at any time; code drops the write-control command in wait or stop
// R7: Bit 7 permits background; reset clears
// R8: Bit 6 reads one in background mode
// R9: Breakpoint off ignores type and match
// R10: Force type breaks at next boundary
// R11: Tag type marks fetched opcode
// R12: Bit 3 resets zero; one selects bus
// R13: Bit 2 shows wait or stop
// R14: Wait or stop blocks most commands
// R15: Host confirms active bit after forcing
// R16: Bit 1 set on wait-stop access failure
// R17: Host recovers failure via background command
// R18: Bit 0 unused, never signals failure
// R19: Host programs breakpoint while in background
// R20: Background command ignored unless permitted
// R21: Read-status command returns register
// R22: Write-control command sets writable bits
// R23: Break-read command returns match value
// R24: Bit 0 always reads zero
`timescale 1ns/1ps
module dbgsc_debug_regs
#(
  parameter int ADDR_W = 16
)
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Decoded serial debug commands
  input wire logic cmd_valid_in,
  input wire logic [dbgsc_pkg::DBGSC_CODE_W-1:0] cmd_code_in,
  input wire logic [ADDR_W-1:0] cmd_data_in,
  // Serial command answers
  output logic rsp_valid_out,
  output logic [ADDR_W-1:0] rsp_data_out,
  // Processor bus observation
  input wire logic cpu_access_valid_in,
  input wire logic cpu_opcode_fetch_in,
  input wire logic [ADDR_W-1:0] cpu_addr_in,
  input wire logic cpu_insn_boundary_in,
  // Processor mode reports
  input wire logic cpu_wait_stop_in,
  input wire logic cpu_bgnd_entered_in,
  input wire logic cpu_resume_in,
  input wire logic cpu_mem_fail_in,
  input wire logic cpu_mem_ok_in,
  // Requests to the processor
  output logic bgnd_request_out,
  output logic fetch_tag_out,
  output logic bgnd_mode_active_out,
  output logic comm_clock_select_out
);
  import dbgsc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic bgnd_mode_permit;
    logic bgnd_mode_active;
    logic break_enable;
    logic break_force_or_tag;
    logic comm_clock_select;
    logic ws_latched;
    logic wait_stop_fail_flag;
    logic [ADDR_W-1:0] debug_break_match;
    logic force_pend;
    logic bgnd_req;
    logic tag;
    logic rsp_valid;
    logic [ADDR_W-1:0] rsp_data;
  } dbgsc_state_t;

  dbgsc_state_t q;
  dbgsc_state_t next_q;
  dbgsc_op_t op;
  logic hit;
  logic match_en;
  logic wait_stop_flag;

  // Status byte as seen by the read-status command
  function automatic logic [DBGSC_STAT_W-1:0] status_byte(input dbgsc_state_t s, input logic ws);
    logic [DBGSC_STAT_W-1:0] b;
    b = '0;
    b[DBGSC_BIT_PERMIT] = s.bgnd_mode_permit;
    b[DBGSC_BIT_ACTIVE] = s.bgnd_mode_active;
    b[DBGSC_BIT_BRK_EN] = s.break_enable;
    b[DBGSC_BIT_FORCE_TAG] = s.break_force_or_tag;
    b[DBGSC_BIT_CLK_SEL] = s.comm_clock_select;
    b[DBGSC_BIT_WAIT_STOP] = ws;
    b[DBGSC_BIT_WS_FAIL] = s.wait_stop_fail_flag;
    b[DBGSC_BIT_SLOW_FAIL] = 1'b0; // R18
    return b;
  endfunction

  // ----------------------------------------
  // Command decode and address compare
  // ----------------------------------------
  dbgsc_cmd_decode u_decode
  (
    .cmd_valid_in(cmd_valid_in),
    .cmd_code_in(cmd_code_in),
    .cpu_wait_stop_in(cpu_wait_stop_in),
    .op_out(op)
  );

  dbgsc_addr_match #(.WIDTH(ADDR_W)) u_match
  (
    .enable_in(match_en),
    .addr_in(cpu_addr_in),
    .match_in(q.debug_break_match),
    .hit_out(hit)
  );

  always_comb
  begin
    match_en = q.break_enable && q.bgnd_mode_permit && !q.bgnd_mode_active; // R9
    wait_stop_flag = cpu_wait_stop_in || q.ws_latched; // R13
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    next_q = q;
    next_q.rsp_valid = 1'b0;
    next_q.bgnd_req = 1'b0;
    next_q.tag = 1'b0;

    // Mode tracking, entry wins over resume
    if (cpu_resume_in)
    begin
      next_q.bgnd_mode_active = 1'b0;
      next_q.ws_latched = 1'b0;
    end
    if (cpu_bgnd_entered_in)
    begin
      next_q.bgnd_mode_active = 1'b1; // R8
      next_q.force_pend = 1'b0;
    end

    // Access failure flag, set wins over clear
    if (cpu_mem_ok_in)
    begin
      next_q.wait_stop_fail_flag = 1'b0;
    end
    if (cpu_mem_fail_in)
    begin
      next_q.wait_stop_fail_flag = 1'b1; // R16
    end

    // Forced breakpoint waits for an instruction boundary
    if (q.force_pend && cpu_insn_boundary_in && q.bgnd_mode_permit)
    begin
      next_q.bgnd_req = 1'b1; // R10
      next_q.force_pend = 1'b0;
    end
    if (!match_en)
    begin
      next_q.force_pend = 1'b0; // R9
    end
    else if (hit && q.break_force_or_tag && cpu_access_valid_in)
    begin
      next_q.force_pend = 1'b1; // R10
    end

    // Tagged breakpoint marks the opcode being fetched
    if (hit && !q.break_force_or_tag && cpu_opcode_fetch_in)
    begin
      next_q.tag = 1'b1; // R11
    end

    // Serial commands; no path from the processor bus writes here
    case (op) // R3
      DBGSC_OP_BGND:
      begin
        if (q.bgnd_mode_permit && !q.bgnd_mode_active) // R20
        begin
          next_q.bgnd_req = 1'b1; // R14
          if (cpu_wait_stop_in)
          begin
            next_q.ws_latched = 1'b1; // R13
          end
        end
      end
      DBGSC_OP_STAT_RD:
      begin
        next_q.rsp_valid = 1'b1;
        next_q.rsp_data = {{(ADDR_W-DBGSC_STAT_W){1'b0}}, status_byte(q, wait_stop_flag)}; // R21
      end
      DBGSC_OP_CTRL_WR: // R5
      begin
        if (!q.bgnd_mode_active)
        begin
          next_q.bgnd_mode_permit = cmd_data_in[DBGSC_BIT_PERMIT]; // R4
        end
        next_q.break_enable = cmd_data_in[DBGSC_BIT_BRK_EN]; // R22
        next_q.break_force_or_tag = cmd_data_in[DBGSC_BIT_FORCE_TAG]; // R22
        next_q.comm_clock_select = cmd_data_in[DBGSC_BIT_CLK_SEL]; // R6
      end
      DBGSC_OP_BRK_RD:
      begin
        next_q.rsp_valid = 1'b1;
        next_q.rsp_data = q.debug_break_match; // R23
      end
      DBGSC_OP_BRK_WR:
      begin
        next_q.debug_break_match = cmd_data_in;
      end
      DBGSC_OP_NONE:
      begin
        next_q.rsp_valid = 1'b0;
      end
      default:
      begin
        next_q.rsp_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      q.bgnd_mode_permit <= DBGSC_CTRL_RESET[DBGSC_BIT_PERMIT]; // R7
      q.bgnd_mode_active <= DBGSC_CTRL_RESET[DBGSC_BIT_ACTIVE];
      q.break_enable <= DBGSC_CTRL_RESET[DBGSC_BIT_BRK_EN];
      q.break_force_or_tag <= DBGSC_CTRL_RESET[DBGSC_BIT_FORCE_TAG];
      q.comm_clock_select <= DBGSC_CTRL_RESET[DBGSC_BIT_CLK_SEL]; // R12
      q.ws_latched <= 1'b0;
      q.wait_stop_fail_flag <= DBGSC_CTRL_RESET[DBGSC_BIT_WS_FAIL];
      q.debug_break_match <= DBGSC_MATCH_RESET;
      q.force_pend <= 1'b0;
      q.bgnd_req <= 1'b0;
      q.tag <= 1'b0;
      q.rsp_valid <= 1'b0;
      q.rsp_data <= '0;
    end
    else
    begin
      q <= next_q; // R1
    end
  end

  always_comb
  begin
    rsp_valid_out = q.rsp_valid;
    rsp_data_out = q.rsp_data;
    bgnd_request_out = q.bgnd_req;
    fetch_tag_out = q.tag;
    bgnd_mode_active_out = q.bgnd_mode_active;
    comm_clock_select_out = q.comm_clock_select; // R12
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  property p_no_request_unpermitted;
    !q.bgnd_mode_permit |=> !bgnd_request_out;
  endproperty
  a_no_request_unpermitted: assert property (p_no_request_unpermitted) else $error("request without permit"); // R20

  property p_permit_frozen;
    q.bgnd_mode_active && op == DBGSC_OP_CTRL_WR |=> $stable(q.bgnd_mode_permit);
  endproperty
  a_permit_frozen: assert property (p_permit_frozen) else $error("permit changed in background"); // R4

  property p_status_read_only;
    op == DBGSC_OP_CTRL_WR && !cpu_bgnd_entered_in && !cpu_resume_in && !cpu_mem_fail_in && !cpu_mem_ok_in
      |=> $stable(q.bgnd_mode_active) && $stable(q.wait_stop_fail_flag) && $stable(q.ws_latched);
  endproperty
  a_status_read_only: assert property (p_status_read_only) else $error("status bit written"); // R5

  property p_clock_select_write;
    op == DBGSC_OP_CTRL_WR |=> comm_clock_select_out == $past(cmd_data_in[DBGSC_BIT_CLK_SEL]);
  endproperty
  a_clock_select_write: assert property (p_clock_select_write) else $error("clock select not written"); // R6

  property p_status_answer;
    op == DBGSC_OP_STAT_RD
      |=> rsp_valid_out && rsp_data_out[DBGSC_BIT_ACTIVE] == $past(q.bgnd_mode_active)
        && rsp_data_out[DBGSC_BIT_SLOW_FAIL] == 1'b0
        && rsp_data_out[DBGSC_BIT_WAIT_STOP] == $past(wait_stop_flag);
  endproperty
  a_status_answer: assert property (p_status_answer) else $error("bad status answer"); // R24

  property p_break_answer;
    op == DBGSC_OP_BRK_RD |=> rsp_valid_out && rsp_data_out == $past(q.debug_break_match);
  endproperty
  a_break_answer: assert property (p_break_answer) else $error("bad break answer"); // R23

  property p_force_fires;
    q.force_pend && cpu_insn_boundary_in && q.bgnd_mode_permit |=> bgnd_request_out;
  endproperty
  a_force_fires: assert property (p_force_fires) else $error("forced break missed"); // R10

  property p_tag_fires;
    match_en && !q.break_force_or_tag && cpu_opcode_fetch_in && cpu_addr_in == q.debug_break_match |=> fetch_tag_out;
  endproperty
  a_tag_fires: assert property (p_tag_fires) else $error("opcode tag missed"); // R11

  property p_disabled_quiet;
    !q.break_enable |=> !fetch_tag_out && !q.force_pend;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled breakpoint acted"); // R9

  property p_fail_flag;
    cpu_mem_fail_in |=> q.wait_stop_fail_flag;
  endproperty
  a_fail_flag: assert property (p_fail_flag) else $error("failure flag not set"); // R16

  property p_wait_stop_blocks;
    cmd_valid_in && cpu_wait_stop_in && cmd_code_in == DBGSC_CMD_BREAK_WRITE |=> $stable(q.debug_break_match);
  endproperty
  a_wait_stop_blocks: assert property (p_wait_stop_blocks) else $error("command ran in wait or stop"); // R14

endmodule

// File: rtl/dbgsc_pkg.sv
package dbgsc_pkg;

  // ----------------------------------------
  // Serial command codes
  // ----------------------------------------
  localparam logic [7:0] DBGSC_CMD_BACKGROUND = 8'h90;
  localparam logic [7:0] DBGSC_CMD_READ_STATUS = 8'he4;
  localparam logic [7:0] DBGSC_CMD_WRITE_CONTROL = 8'hc4;
  localparam logic [7:0] DBGSC_CMD_BREAK_READ = 8'he2;
  localparam logic [7:0] DBGSC_CMD_BREAK_WRITE = 8'hc2;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DBGSC_CODE_W = 8;
  localparam int DBGSC_STAT_W = 8;
  localparam int DBGSC_ADDR_W = 16;

  // ----------------------------------------
  // Status and control bit positions
  // ----------------------------------------
  localparam int DBGSC_BIT_PERMIT = 7;
  localparam int DBGSC_BIT_ACTIVE = 6;
  localparam int DBGSC_BIT_BRK_EN = 5;
  localparam int DBGSC_BIT_FORCE_TAG = 4;
  localparam int DBGSC_BIT_CLK_SEL = 3;
  localparam int DBGSC_BIT_WAIT_STOP = 2;
  localparam int DBGSC_BIT_WS_FAIL = 1;
  localparam int DBGSC_BIT_SLOW_FAIL = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] DBGSC_CTRL_RESET = 8'h00;
  localparam logic [15:0] DBGSC_MATCH_RESET = 16'h0000;

  // ----------------------------------------
  // Accepted command, one-hot
  // ----------------------------------------
  typedef enum logic [5:0] {
    DBGSC_OP_NONE = 6'b000001,
    DBGSC_OP_BGND = 6'b000010,
    DBGSC_OP_STAT_RD = 6'b000100,
    DBGSC_OP_CTRL_WR = 6'b001000,
    DBGSC_OP_BRK_RD = 6'b010000,
    DBGSC_OP_BRK_WR = 6'b100000
  } dbgsc_op_t;

endpackage

// File: verification/dbgsc_cpu_model.sv
`timescale 1ns/1ps
module dbgsc_cpu_model
(
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  // Device request and test controls
  input wire logic bgnd_request_in,
  input wire logic sleep_in,
  input wire logic go_in,
  // Processor reports
  output logic bgnd_entered_out,
  output logic resume_out,
  output logic wait_stop_out
);
  logic halted;

  // Halts one cycle after a request, leaving wait or stop on the way
  always_ff @(posedge sys_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      halted <= 1'b0;
      bgnd_entered_out <= 1'b0;
      resume_out <= 1'b0;
      wait_stop_out <= 1'b0;
    end
    else
    begin
      bgnd_entered_out <= bgnd_request_in && !halted;
      resume_out <= go_in && halted;
      if (bgnd_request_in)
      begin
        halted <= 1'b1;
        wait_stop_out <= 1'b0;
      end
      else if (go_in)
        halted <= 1'b0;
      else if (sleep_in)
        wait_stop_out <= 1'b1;
    end
  end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import dbgsc_pkg::*;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cv = 1'b0;
  logic [7:0] code = 8'h00;
  logic [15:0] data = 16'h0000;
  logic acc = 1'b0;
  logic fetch = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic bnd = 1'b0;
  logic mfail = 1'b0;
  logic mok = 1'b0;
  logic sleep = 1'b0;
  logic go = 1'b0;
  logic rv, breq, tag, act, csel, ws, ent, res;
  logic [15:0] rd_data;
  int err_count = 0;
  int n_compared = 0;

  always #2 clk = ~clk;

  dbgsc_debug_regs #(.ADDR_W(16)) dut_u (.sys_clk_in(clk), .reset_n_in(rst_n), .cmd_valid_in(cv),
    .cmd_code_in(code), .cmd_data_in(data), .rsp_valid_out(rv), .rsp_data_out(rd_data),
    .cpu_access_valid_in(acc), .cpu_opcode_fetch_in(fetch), .cpu_addr_in(addr),
    .cpu_insn_boundary_in(bnd), .cpu_wait_stop_in(ws), .cpu_bgnd_entered_in(ent),
    .cpu_resume_in(res), .cpu_mem_fail_in(mfail), .cpu_mem_ok_in(mok), .bgnd_request_out(breq),
    .fetch_tag_out(tag), .bgnd_mode_active_out(act), .comm_clock_select_out(csel));

  dbgsc_cpu_model cpu_u (.sys_clk_in(clk), .reset_n_in(rst_n), .bgnd_request_in(breq),
    .sleep_in(sleep), .go_in(go), .bgnd_entered_out(ent), .resume_out(res), .wait_stop_out(ws));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    cv <= 1'b1;
    code <= c;
    data <= d;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] c, input logic v, input logic [15:0] exp);
    send(c, 16'h0000);
    check("rsp_valid", {15'h0, rv}, {15'h0, v});
    if (v)
      check("rsp_data", rd_data, exp);
  endtask

  task automatic bus(input logic f, input logic [15:0] a, input logic b);
    @(posedge clk);
    acc <= 1'b1;
    fetch <= f;
    addr <= a;
    bnd <= b;
    @(posedge clk);
    acc <= 1'b0;
    fetch <= 1'b0;
    bnd <= 1'b0;
    #1;
  endtask

  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: go <= 1'b1;
      1: sleep <= 1'b1;
      2: mfail <= 1'b1;
      default: mok <= 1'b1;
    endcase
    @(posedge clk);
    {go, sleep, mfail, mok} <= 4'h0;
  endtask

  task automatic wait_active(input logic v);
    for (int i = 0; i < 20 && act !== v; i++)
    begin
      @(posedge clk);
      #1;
    end
    check("active", {15'h0, act}, {15'h0, v});
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_and_rw();
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h0000);
    rd(DBGSC_CMD_BREAK_READ, 1'b1, 16'h0000);
    check("clk_sel", {15'h0, csel}, 16'h0000);
    send(DBGSC_CMD_WRITE_CONTROL, 16'hffff);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h00b8);
    check("clk_sel", {15'h0, csel}, 16'h0001);
    send(DBGSC_CMD_BREAK_WRITE, 16'h1234);
    rd(DBGSC_CMD_BREAK_READ, 1'b1, 16'h1234);
  endtask

  task automatic t_force_and_active();
    bus(1'b0, 16'h1234, 1'b0);
    check("bgnd_req", {15'h0, breq}, 16'h0000);
    bus(1'b0, 16'h0010, 1'b1);
    check("bgnd_req", {15'h0, breq}, 16'h0001);
    wait_active(1'b1);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h00f8);
    send(DBGSC_CMD_BREAK_WRITE, 16'h4321);
    rd(DBGSC_CMD_BREAK_READ, 1'b1, 16'h4321);
    send(DBGSC_CMD_BREAK_WRITE, 16'h1234);
    send(DBGSC_CMD_WRITE_CONTROL, 16'h0000);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h00c0);
    check("clk_sel", {15'h0, csel}, 16'h0000);
    pulse(0);
    wait_active(1'b0);
  endtask

  task automatic t_tag_and_off();
    send(DBGSC_CMD_WRITE_CONTROL, 16'h00a0);
    bus(1'b1, 16'h1234, 1'b0);
    check("tag", {15'h0, tag}, 16'h0001);
    bus(1'b0, 16'h1234, 1'b0);
    check("tag", {15'h0, tag}, 16'h0000);
    send(DBGSC_CMD_WRITE_CONTROL, 16'h0080);
    bus(1'b1, 16'h1234, 1'b1);
    check("tag_off", {14'h0, tag, breq}, 16'h0000);
  endtask

  task automatic t_wait_stop();
    pulse(1);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h0084);
    send(DBGSC_CMD_BREAK_WRITE, 16'h5555);
    rd(DBGSC_CMD_BREAK_READ, 1'b0, 16'h0000);
    send(DBGSC_CMD_BACKGROUND, 16'h0000);
    wait_active(1'b1);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h00c4);
    rd(DBGSC_CMD_BREAK_READ, 1'b1, 16'h1234);
    pulse(0);
    wait_active(1'b0);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h0080);
  endtask

  task automatic t_fail_recovery();
    pulse(2);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h0082);
    send(DBGSC_CMD_BACKGROUND, 16'h0000);
    wait_active(1'b1);
    pulse(3);
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h00c0);
    pulse(0);
    wait_active(1'b0);
  endtask

  task automatic t_permit_off_and_reset();
    send(DBGSC_CMD_WRITE_CONTROL, 16'h0000);
    send(DBGSC_CMD_BACKGROUND, 16'h0000);
    check("bgnd_req", {15'h0, breq}, 16'h0000);
    repeat (4) @(posedge clk);
    #1;
    check("active", {15'h0, act}, 16'h0000);
    send(DBGSC_CMD_WRITE_CONTROL, 16'h0088);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(DBGSC_CMD_READ_STATUS, 1'b1, 16'h0000);
    check("clk_sel", {15'h0, csel}, 16'h0000);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset_and_rw();
    t_force_and_active();
    t_tag_and_off();
    t_wait_stop();
    t_fail_recovery();
    t_permit_off_and_reset();
    final_report();
  end

  initial
  begin
    #(4 * 5000);
    err_count++;
    final_report();
  end
endmodule
